// File: hw/dsr_consts.vh
`ifndef DSR_CONSTS_VH
`define DSR_CONSTS_VH

// ==========================================
// record byte offsets (subindex of the record)
`define DSR_OFS_BITS_PER_CH   8'h07
`define DSR_OFS_CH_COUNT      8'h08
`define DSR_OFS_GROUP_ERR     8'h09
`define DSR_OFS_CH0_ERR       8'h0a
`define DSR_OFS_CH3_ERR       8'h0d
`define DSR_OFS_RSVD_FIRST    8'h0e
`define DSR_OFS_RSVD_LAST     8'h11
`define DSR_OFS_STAMP         8'h13
`define DSR_OFS_STAMP_LAST    8'h16

// ==========================================
// fixed values
`define DSR_BITS_PER_CH_VAL   8'h08
`define DSR_CH_COUNT_VAL      8'h04

// ==========================================
// per-channel error byte fields
`define DSR_BIT_PARAM_ERR     0
`define DSR_BIT_UNDERRANGE    6
`define DSR_BIT_OVERRANGE     7

// ==========================================
// timing
`define DSR_CLK_PERIOD_NS     25
`define DSR_TICK_NS           1000
`define DSR_TICK_CYCLES       (`DSR_TICK_NS / `DSR_CLK_PERIOD_NS)
`define DSR_BLINK_HZ          2
`define DSR_BLINK_HALF_NS     (1000000000 / (2 * `DSR_BLINK_HZ))
`define DSR_BLINK_HALF_CYCLES (`DSR_BLINK_HALF_NS / `DSR_CLK_PERIOD_NS)

`endif

// File: hw/dsr_diag_record.v
`timescale 1ns/1ps
`include "dsr_consts.vh"
// Summary of operation
// - diagnostic bits per channel byte reads fixed value eight
// - channel count byte reads fixed value four
// - group error byte bit n set on error in channel group n
// - channel error byte bit zero set on parameter error
// - channel error byte bit six set on measuring range underflow
// - channel error byte bit seven set on measuring range overflow
// - timestamp captures microsecond ticker when a diagnostic event is recorded
// - ticker starts from zero at power-on, one step per microsecond
// - ticker wraps to zero after its maximum 32-bit count
// - fault LED lit on module error while bus power is good and no configuration error is present
// - run LED off when bus communication is impossible
// - run and fault both dark on bus power supply error
// - fault LED blinks at two hertz on configuration error
// - channel LED lit on range, parameter or wire-break error
// - errors light channel LED and are recorded, no interrupt raised
module dsr_diag_record #(
  parameter BLINK_HALF_CYCLES = `DSR_BLINK_HALF_CYCLES,
  parameter NUM_CH            = 4
) (
  input  wire              SYS_CLK,
  input  wire              RST_N,
  input  wire [7:0]        RD_ADDR,
  output reg  [7:0]        RD_DATA,
  input  wire [NUM_CH-1:0] CH_PARAM_ERR,
  input  wire [NUM_CH-1:0] CH_UNDERRANGE,
  input  wire [NUM_CH-1:0] CH_OVERRANGE,
  input  wire [NUM_CH-1:0] CH_WIRE_BREAK,
  input  wire              BUS_COMM_OK,
  input  wire              BUS_POWER_OK,
  input  wire              MODULE_ERR,
  input  wire              CONFIG_ERR,
  output reg               RUN_LED,
  output reg               MODULE_FAULT_LED,
  output reg  [NUM_CH-1:0] CHANNEL_STATUS_LED,
  output reg  [31:0]       DIAG_TIMESTAMP_US
);

  localparam NIN = 4 * NUM_CH + 4;

  // ==========================================
  // input synchronisers
  reg  [NIN-1:0] sync1_q;
  reg  [NIN-1:0] sync2_q;
  wire [NIN-1:0] raw_in = {CH_PARAM_ERR, CH_UNDERRANGE, CH_OVERRANGE, CH_WIRE_BREAK,
                           BUS_COMM_OK, BUS_POWER_OK, MODULE_ERR, CONFIG_ERR};

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      sync1_q <= {NIN{1'b0}};
      sync2_q <= {NIN{1'b0}};
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  wire [NUM_CH-1:0] s_param = sync2_q[4*NUM_CH+3:3*NUM_CH+4];
  wire [NUM_CH-1:0] s_under = sync2_q[3*NUM_CH+3:2*NUM_CH+4];
  wire [NUM_CH-1:0] s_over  = sync2_q[2*NUM_CH+3:NUM_CH+4];
  wire [NUM_CH-1:0] s_wire  = sync2_q[NUM_CH+3:4];
  wire              s_bus   = sync2_q[3];
  wire              s_pwr   = sync2_q[2];
  wire              s_mod   = sync2_q[1];
  wire              s_cfg   = sync2_q[0];

  // ==========================================
  // microsecond ticker
  reg  [7:0]  pre_q;
  reg  [31:0] ticker_q;
  wire        us_tick = (pre_q == `DSR_TICK_CYCLES - 1);

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pre_q    <= 8'h00;
      ticker_q <= 32'h0000_0000;
    end else begin
      pre_q <= us_tick ? 8'h00 : pre_q + 8'h01;
      if (us_tick)
        ticker_q <= ticker_q + 32'h0000_0001;
    end
  end

  // ==========================================
  // per-channel error bytes and group flags
  wire [8*NUM_CH-1:0] ch_err_next;
  wire [NUM_CH-1:0]   grp_next;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      assign ch_err_next[8*g+7:8*g] = {s_over[g], s_under[g], 5'h00, s_param[g]};
      assign grp_next[g] = s_over[g] | s_under[g] | s_param[g] | s_wire[g];
    end
  endgenerate

  reg [8*NUM_CH-1:0] ch_err_q;
  reg [NUM_CH-1:0]   grp_q;

  // a rise of any flag counts as a new diagnostic event; clearing does not restamp
  wire diag_event = |({ch_err_next, grp_next} & ~{ch_err_q, grp_q});

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ch_err_q          <= {8*NUM_CH{1'b0}};
      grp_q             <= {NUM_CH{1'b0}};
      DIAG_TIMESTAMP_US <= 32'h0000_0000;
    end else begin
      ch_err_q <= ch_err_next;
      grp_q    <= grp_next;
      if (diag_event)
        DIAG_TIMESTAMP_US <= ticker_q;
    end
  end

  // ==========================================
  // record read port
  reg [7:0] rd_d;
  reg [7:0] idx;

  always @* begin
    rd_d = 8'h00;
    idx  = RD_ADDR - `DSR_OFS_CH0_ERR;
    if (RD_ADDR == `DSR_OFS_BITS_PER_CH)
      rd_d = `DSR_BITS_PER_CH_VAL;
    else if (RD_ADDR == `DSR_OFS_CH_COUNT)
      rd_d = `DSR_CH_COUNT_VAL;
    else if (RD_ADDR == `DSR_OFS_GROUP_ERR)
      rd_d = {{(8-NUM_CH){1'b0}}, grp_q};
    else if (RD_ADDR >= `DSR_OFS_CH0_ERR && RD_ADDR <= `DSR_OFS_CH3_ERR)
      rd_d = ch_err_q[8*idx[1:0] +: 8];
    else if (RD_ADDR >= `DSR_OFS_STAMP && RD_ADDR <= `DSR_OFS_STAMP_LAST) begin
      idx  = RD_ADDR - `DSR_OFS_STAMP;
      rd_d = DIAG_TIMESTAMP_US[8*idx[1:0] +: 8];
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N)
      RD_DATA <= 8'h00;
    else
      RD_DATA <= rd_d;
  end

  // ==========================================
  // status LEDs
  reg [31:0] blink_cnt_q;
  reg        blink_q;

  // free-running so blinking phase is independent of when the error appears
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= 1'b0;
    end else if (blink_cnt_q == BLINK_HALF_CYCLES - 1) begin
      blink_cnt_q <= 32'h0000_0000;
      blink_q     <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RUN_LED            <= 1'b0;
      MODULE_FAULT_LED   <= 1'b0;
      CHANNEL_STATUS_LED <= {NUM_CH{1'b0}};
    end else begin
      CHANNEL_STATUS_LED <= grp_next;
      if (!s_pwr) begin
        RUN_LED          <= 1'b0;
        MODULE_FAULT_LED <= 1'b0;
      end else begin
        RUN_LED <= s_bus;
        MODULE_FAULT_LED <= s_cfg ? blink_q : s_mod;
      end
    end
  end

endmodule // dsr_diag_record

// File: verification/dsr_chk.sv
`timescale 1ns/1ps
// ====
// record and led checks
module dsr_chk #(
  parameter BLINK_HALF_CYCLES = 8,
  parameter NUM_CH            = 4
) (
  input wire              SYS_CLK,
  input wire              RST_N,
  input wire [7:0]        RD_ADDR,
  input wire [7:0]        RD_DATA,
  input wire [NUM_CH-1:0] CH_PARAM_ERR,
  input wire [NUM_CH-1:0] CH_UNDERRANGE,
  input wire [NUM_CH-1:0] CH_OVERRANGE,
  input wire [NUM_CH-1:0] CH_WIRE_BREAK,
  input wire              BUS_COMM_OK,
  input wire              BUS_POWER_OK,
  input wire              MODULE_ERR,
  input wire              CONFIG_ERR,
  input wire              RUN_LED,
  input wire              MODULE_FAULT_LED,
  input wire [NUM_CH-1:0] CHANNEL_STATUS_LED,
  input wire [31:0]       DIAG_TIMESTAMP_US
);
  wire [NUM_CH-1:0] any_err = CH_PARAM_ERR | CH_UNDERRANGE | CH_OVERRANGE | CH_WIRE_BREAK;
  reg  [2:0]        up_q = 3'h0;
  // led checks wait out the input synchronisers after reset
  wire              live = up_q > 3'h4;
  always @(posedge SYS_CLK) up_q <= !RST_N ? 3'h0 : up_q + {2'h0, up_q != 3'h7};
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  chk_bits_count: assert property (RD_ADDR == 8'h07 |=> RD_DATA == 8'h08)
    else $error("bit count byte");
  chk_chan_count: assert property (RD_ADDR == 8'h08 |=> RD_DATA == 8'h04)
    else $error("channel count byte");
  chk_group_rsvd: assert property (RD_ADDR == 8'h09 |=> RD_DATA[7:4] == 4'h0)
    else $error("group byte high bits");
  chk_chan_rsvd: assert property (RD_ADDR inside {[8'h0a:8'h0d]} |=> RD_DATA[5:1] == 5'h0)
    else $error("channel byte middle bits");
  chk_unused_zero: assert property (RD_ADDR inside {[8'h0e:8'h12]} |=> RD_DATA == 8'h00)
    else $error("unused byte");
  chk_power_dark: assert property (live && !$past(BUS_POWER_OK, 3) |-> !RUN_LED && !MODULE_FAULT_LED)
    else $error("power fault leds");
  chk_run_bus: assert property (live && $past(BUS_POWER_OK, 3) |-> RUN_LED == $past(BUS_COMM_OK, 3))
    else $error("run led");
  chk_fault_led: assert property (
    live && $past(BUS_POWER_OK, 3) && !$past(CONFIG_ERR, 3)
    |-> MODULE_FAULT_LED == $past(MODULE_ERR, 3)) else $error("fault led");
  chk_chan_led: assert property (live |-> CHANNEL_STATUS_LED == $past(any_err, 3))
    else $error("channel led");
  chk_blink_half: assert property (
    live && $past(CONFIG_ERR, 4) && $past(BUS_POWER_OK, 4)
    && $rose(MODULE_FAULT_LED) |-> MODULE_FAULT_LED[*8] ##1 !MODULE_FAULT_LED)
    else $error("blink period");
endmodule // dsr_chk

bind dsr_diag_record dsr_chk #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES), .NUM_CH(NUM_CH)) u_chk (.*);

// File: verification/dsr_coupler.sv
`timescale 1ns/1ps
// ====
// coupler side reader, one cycle latency
module dsr_coupler (
  input  wire       clk,
  output reg  [7:0] addr,
  input  wire [7:0] data
);
  initial addr = 8'h00;
  task automatic rd(input [7:0] a, output [7:0] d);
    @(posedge clk) addr <= a;
    @(posedge clk);
    @(posedge clk) d = data;
  endtask
endmodule // dsr_coupler

// File: verification/test_diag_record_and_status_leds.sv
`timescale 1ns/1ps
module test_diag_record_and_status_leds;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  pe = 4'h0, ur = 4'h0, ovr = 4'h0, wb = 4'h0;
  reg         comm = 1'b1, pwr = 1'b1, merr = 1'b0, cerr = 1'b0;
  wire [7:0]  ra, rdat;
  wire        run, mf;
  wire [3:0]  led;
  wire [31:0] ts;
  integer     fail_count = 0, checked = 0, i, n = 0;
  reg  [7:0]  d;
  reg  [4:0]  lt [0:2];
  always #12.5 clk = ~clk;
  dsr_coupler u_cpl (.clk(clk), .addr(ra), .data(rdat));
  dsr_diag_record #(.BLINK_HALF_CYCLES(8)) u_dut (.SYS_CLK(clk), .RST_N(rst_n),
    .RD_ADDR(ra), .RD_DATA(rdat), .CH_PARAM_ERR(pe), .CH_UNDERRANGE(ur),
    .CH_OVERRANGE(ovr), .CH_WIRE_BREAK(wb), .BUS_COMM_OK(comm), .BUS_POWER_OK(pwr),
    .MODULE_ERR(merr), .CONFIG_ERR(cerr), .RUN_LED(run), .MODULE_FAULT_LED(mf),
    .CHANNEL_STATUS_LED(led), .DIAG_TIMESTAMP_US(ts));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin u_cpl.rd(a, d); chk(d, e); end
  endtask
  task summarize;
    begin
      $display("checked %0d failed %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    fail_count = fail_count + 1;
    summarize;
  end
  // ====
  // sequence; errors rise near cycle 120 so the ticker reads 2
  initial begin
    lt[0] = 5'b10101; lt[1] = 5'b01100; lt[2] = 5'b11111;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdc(8'h07, 8'h08);
    rdc(8'h08, 8'h04);
    for (i = 14; i < 19; i = i + 1) rdc(i[7:0], 8'h00);
    rdc(8'h00, 8'h00);
    rdc(8'h17, 8'h00);
    repeat (4) @(posedge clk);
    chk({run, mf}, 2'b10);
    repeat (69) @(posedge clk);
    pe <= 4'h1; ur <= 4'h2; ovr <= 4'h4; wb <= 4'h8;
    repeat (5) @(posedge clk);
    chk(led, 4'hf);
    chk(ts, 32'h2);
    rdc(8'h09, 8'h0f);
    rdc(8'h0a, 8'h01);
    rdc(8'h0b, 8'h40);
    rdc(8'h0c, 8'h80);
    rdc(8'h0d, 8'h00);
    rdc(8'h13, 8'h02);
    for (i = 0; i < 3; i = i + 1) begin
      {pwr, comm, merr} <= lt[i][4:2];
      repeat (5) @(posedge clk);
      chk({run, mf}, lt[i][1:0]);
    end
    cerr <= 1'b1;
    repeat (5) @(posedge clk);
    #1 d[0] = mf;
    for (i = 0; i < 32; i = i + 1) begin
      @(posedge clk); #1;
      if (mf !== d[0]) n = n + 1;
      d[0] = mf;
    end
    chk(n, 4);
    summarize;
  end
endmodule // test_diag_record_and_status_leds
